// *** rtl/ioctl_pkg.sv ***
package ioctl_pkg;
   // array shape
   localparam int NLINE = 12;
   localparam int NCELL = 8;
   localparam int NDED = 6;
   localparam int NDCLK = 2;
   localparam int NGLOB = 4;
   localparam int NROW = 3;
   localparam int ROW_CH = 144;
   localparam int ROW_PER = 18;
   localparam int COL_CH = 24;
   localparam int COL_PER = 16;
   localparam int COL_STEP = 8;
   localparam int COL_FIRST = 6;
   localparam int NSYNC = 18;
   // register bus
   localparam int AW = 6;
   localparam int DW = 32;
   localparam logic [5:0] ADDR_SRC0 = 6'h00;
   localparam logic [5:0] ADDR_CELL0 = 6'h10;
   localparam logic [5:0] ADDR_GLOB = 6'h18;
   localparam logic [5:0] ADDR_STAT = 6'h19;
   // line source word fields
   localparam int SRC_LSB = 0;
   localparam int ROWF_LSB = 4;
   localparam logic [2:0] SRC_ROWCELL = 3'h6;
   localparam logic [2:0] SRC_COLROUTE = 3'h7;
   // cell config word fields
   localparam int DIR_BIT = 0;
   localparam int CLK_LSB = 1;
   localparam int CLR_LSB = 3;
   localparam int CE_LSB = 5;
   localparam int OE_LSB = 8;
   localparam int RSEL_LSB = 12;
   localparam int CSEL_LSB = 17;
   localparam int LANE_LSB = 21;
   // global control word fields
   localparam int GINT_LSB = 0;
   localparam int OEOPT_BIT = 4;
   // reset values
   localparam logic [31:0] SRC_RST = 32'h0000_0000;
   localparam logic [31:0] CELL_RST = 32'h0000_0FE0;
   localparam logic [31:0] GLOB_RST = 32'h0000_0000;
   // shared roles of the control lines
   localparam int LN_CE0 = 6;
   localparam int LN_PCLOCK_0 = 6;
   localparam int LN_OUT_EN_6 = 7;
   localparam int LN_PCLEAR_0 = 8;
   localparam int LN_OUT_EN_7 = 9;
   localparam int LN_PCLEAR_1 = 10;
   localparam int LN_PCLOCK_1 = 11;
   localparam int GLOB_LINE [NGLOB] = '{6, 7, 9, 11};
   localparam int ASSIGN_ROW [NLINE] = '{0, 0, 1, 1, 2, 2, 0, 0, 1, 1, 2, 2};

   // register clock choice, plain binary codes
   typedef enum logic [1:0] {
      CK_P0 = 2'h0,
      CK_P1 = 2'h1,
      CK_D1 = 2'h2,
      CK_D0 = 2'h3
   } ioctl_clk_e;

   // clock enable pick: lines 0-5 of the enable group, logic cell, or always
   function automatic logic ce_of(input logic [2:0] sel, input logic [11:0] lines,
                                  input logic lc);
      if (sel < 3'h6) begin
         ce_of = lines[LN_CE0 + int'(sel)];
      end else if (sel == 3'h6) begin
         ce_of = lc;
      end else begin
         ce_of = 1'b1;
      end
   endfunction

   // output enable pick: enables 0-7, logic cell, on, or off
   function automatic logic oe_of(input logic [3:0] sel, input logic [11:0] lines,
                                  input logic lc);
      if (sel < 4'h6) begin
         oe_of = lines[sel];
      end else if (sel == 4'h6) begin
         oe_of = lines[LN_OUT_EN_6];
      end else if (sel == 4'h7) begin
         oe_of = lines[LN_OUT_EN_7];
      end else if (sel == 4'h8) begin
         oe_of = lc;
      end else begin
         oe_of = (sel == 4'h9);
      end
   endfunction
endpackage

// *** rtl/ioctl_sync.sv ***
`timescale 1ns/1ps
module ioctl_sync #(parameter int W = 1) (
   // clock and reset
   input wire logic ref_clk,
   input wire logic rstn,
   // raw pin levels
   input wire logic [W-1:0] d,
   // levels safe to use
   output logic [W-1:0] q
);
   // first stage, read only by the second
   logic [W-1:0] meta_q;

   // two flip-flop level crossing
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         meta_q <= '0;
         q <= '0;
      end else begin
         meta_q <= d;
         q <= meta_q;
      end
   end
endmodule

// *** rtl/ioctl_cell.sv ***
`timescale 1ns/1ps
module ioctl_cell #(parameter bit COL_END = 1'b0) (
   // clock and reset
   input wire logic ref_clk,
   input wire logic rstn,
   // chip-wide controls
   input wire logic chip_rst,
   input wire logic pins_off,
   // configuration word
   input wire logic [31:0] cfg,
   // peripheral control lines and dedicated clocks
   input wire logic [11:0] lines,
   input wire logic [1:0] dclk,
   // logic cell enables
   input wire logic lc_ce,
   input wire logic lc_oe,
   // data sources
   input wire logic pad_in,
   input wire logic [17:0] row_sub,
   input wire logic [15:0] col_sub,
   // cell state and pin drive
   output logic cell_q,
   output logic pad_oe_q
);
   // config fields
   logic dir_out;
   logic [1:0] clr_sel;
   logic [2:0] ce_sel;
   logic [3:0] oe_sel;
   logic [4:0] rsel;
   logic [3:0] csel;
   // selected controls
   logic clk_lvl;
   logic clk_prev_q;
   logic clk_edge;
   logic clr_lvl;
   logic ce_lvl;
   logic oe_lvl;
   logic data_d;

   assign dir_out = cfg[ioctl_pkg::DIR_BIT];
   assign clr_sel = cfg[ioctl_pkg::CLR_LSB +: 2];
   assign ce_sel = cfg[ioctl_pkg::CE_LSB +: 3];
   assign oe_sel = cfg[ioctl_pkg::OE_LSB +: 4];
   assign rsel = cfg[ioctl_pkg::RSEL_LSB +: 5];
   assign csel = cfg[ioctl_pkg::CSEL_LSB +: 4];

   // clock source: two peripheral clocks or two dedicated clock pins
   always_comb begin
      unique case (ioctl_pkg::ioctl_clk_e'(cfg[ioctl_pkg::CLK_LSB +: 2]))
         ioctl_pkg::CK_P0: clk_lvl = lines[ioctl_pkg::LN_PCLOCK_0];
         ioctl_pkg::CK_P1: clk_lvl = lines[ioctl_pkg::LN_PCLOCK_1];
         ioctl_pkg::CK_D0: clk_lvl = dclk[0];
         ioctl_pkg::CK_D1: clk_lvl = dclk[1];
      endcase
   end

   // clear source: none, clear 0 or clear 1
   always_comb begin
      unique case (clr_sel)
         2'h1: clr_lvl = lines[ioctl_pkg::LN_PCLEAR_0];
         2'h2: clr_lvl = lines[ioctl_pkg::LN_PCLEAR_1];
         default: clr_lvl = 1'b0;
      endcase
   end

   // enables from shared lines or from a logic cell
   assign ce_lvl = ioctl_pkg::ce_of(ce_sel, lines, lc_ce);
   assign oe_lvl = ioctl_pkg::oe_of(oe_sel, lines, lc_oe);

   // rising edge of the selected clock, seen as a one-cycle enable
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         clk_prev_q <= 1'b0;
      end else begin
         clk_prev_q <= clk_lvl;
      end
   end
   assign clk_edge = clk_lvl & ~clk_prev_q;

   // data: pin for capture, channel multiplexer for output
   always_comb begin
      if (!dir_out) begin
         data_d = pad_in;
      end else if (COL_END) begin
         data_d = col_sub[csel];
      end else if (rsel < 5'h12) begin
         data_d = row_sub[rsel];
      end else begin
         data_d = 1'b0;
      end
   end

   // the one cell register, input capture or output
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         cell_q <= 1'b0;
      end else if (chip_rst) begin
         cell_q <= 1'b0;
      end else if (clr_lvl) begin
         cell_q <= 1'b0;
      end else if (clk_edge && ce_lvl) begin
         cell_q <= data_d;
      end
   end

   // pin buffer enable, forced off by the chip-wide enable
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         pad_oe_q <= 1'b0;
      end else begin
         pad_oe_q <= dir_out & oe_lvl & ~pins_off;
      end
   end
endmodule

// *** rtl/ioctl_top.sv ***
// Local design decisions: the register offsets and the plain strobed port.
`timescale 1ns/1ps
module ioctl_top (
   // clock and reset
   input wire logic ref_clk,
   input wire logic rstn,
   // register port
   input wire logic [5:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [31:0] reg_rdata,
   // dedicated device pins
   input wire logic [5:0] ded_pin,
   input wire logic [1:0] dclk_pin,
   input wire logic chip_rstn_pin,
   input wire logic chip_oe_pin,
   // io cell pins
   input wire logic [7:0] pad_in,
   output logic [7:0] pad_out,
   output logic [7:0] pad_oe,
   // logic array side
   input wire logic [2:0] lc_first,
   input wire logic [7:0] lc_ce,
   input wire logic [7:0] lc_oe,
   input wire logic [143:0] row_chan,
   input wire logic [23:0] col_chan,
   output logic [143:0] row_drive,
   output logic [23:0] col_drive,
   output logic [3:0] fanout_line
);
   // synchronised pins
   logic [17:0] sync_q;
   logic [5:0] ded_s;
   logic [1:0] dclk_s;
   logic chip_rst;
   logic pins_off;
   logic [7:0] pad_s;
   logic [5:0] ded_view;
   // software state
   logic [31:0] src_q [ioctl_pkg::NLINE];
   logic [31:0] cell_cfg_q [ioctl_pkg::NCELL];
   logic [31:0] glob_q;
   logic [31:0] rdata_d;
   logic [31:0] status;
   // control lines and cell state
   logic [11:0] lines_d;
   logic [11:0] lines_q;
   logic [7:0] cell_val;
   logic [143:0] row_drv_d;
   logic [23:0] col_drv_d;
   logic [3:0] fanout_q;

   // register address match
   function automatic logic hit(input logic [5:0] addr, input logic [5:0] base,
                                input int idx);
      hit = (addr == base + 6'(idx));
   endfunction

   // all pin levels cross into ref_clk through two flops
   ioctl_sync #(.W(ioctl_pkg::NSYNC)) u_sync (
      .ref_clk(ref_clk),
      .rstn(rstn),
      .d({pad_in, chip_oe_pin, chip_rstn_pin, dclk_pin, ded_pin}),
      .q(sync_q)
   );
   assign ded_s = sync_q[5:0];
   assign dclk_s = sync_q[7:6];
   assign chip_rst = ~sync_q[8];
   assign pins_off = glob_q[ioctl_pkg::OEOPT_BIT] & ~sync_q[9];
   assign pad_s = sync_q[17:10];

   // a pin whose fan-out line is driven inside reads as zero everywhere
   assign ded_view = ded_s & ~{2'h0, glob_q[ioctl_pkg::GINT_LSB +: 4]};

   // line source registers
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         for (int i = 0; i < ioctl_pkg::NLINE; i++) begin
            src_q[i] <= ioctl_pkg::SRC_RST;
         end
      end else if (reg_wr) begin
         for (int i = 0; i < ioctl_pkg::NLINE; i++) begin
            if (hit(reg_addr, ioctl_pkg::ADDR_SRC0, i)) begin
               src_q[i] <= reg_wdata;
            end
         end
      end
   end

   // cell configuration registers
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         for (int c = 0; c < ioctl_pkg::NCELL; c++) begin
            cell_cfg_q[c] <= ioctl_pkg::CELL_RST;
         end
      end else if (reg_wr) begin
         for (int c = 0; c < ioctl_pkg::NCELL; c++) begin
            if (hit(reg_addr, ioctl_pkg::ADDR_CELL0, c)) begin
               cell_cfg_q[c] <= reg_wdata;
            end
         end
      end
   end

   // global control: internal fan-out drive and chip enable option
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         glob_q <= ioctl_pkg::GLOB_RST;
      end else if (reg_wr && reg_addr == ioctl_pkg::ADDR_GLOB) begin
         glob_q <= {27'h0, reg_wdata[4:0]};
      end
   end

   // status word of live block state
   assign status = {7'h0, chip_rst, fanout_q, lines_q, cell_val};

   // read multiplexer, unmapped reads zero
   always_comb begin
      rdata_d = 32'h0000_0000;
      for (int i = 0; i < ioctl_pkg::NLINE; i++) begin
         if (hit(reg_addr, ioctl_pkg::ADDR_SRC0, i)) begin
            rdata_d = src_q[i];
         end
      end
      for (int c = 0; c < ioctl_pkg::NCELL; c++) begin
         if (hit(reg_addr, ioctl_pkg::ADDR_CELL0, c)) begin
            rdata_d = cell_cfg_q[c];
         end
      end
      if (reg_addr == ioctl_pkg::ADDR_GLOB) begin
         rdata_d = glob_q;
      end else if (reg_addr == ioctl_pkg::ADDR_STAT) begin
         rdata_d = status;
      end
   end

   // read data stand only in the cycle after the strobe
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         reg_rdata <= 32'h0000_0000;
      end else if (reg_rd) begin
         reg_rdata <= rdata_d;
      end else begin
         reg_rdata <= 32'h0000_0000;
      end
   end

   // twelve control lines, each from a pin or a row's first logic cell, or zero when a column route names row 3
   always_comb begin
      for (int i = 0; i < ioctl_pkg::NLINE; i++) begin
         if (src_q[i][2:0] < ioctl_pkg::SRC_ROWCELL) begin
            lines_d[i] = ded_view[src_q[i][2:0]];
         end else if (src_q[i][2:0] == ioctl_pkg::SRC_ROWCELL) begin
            lines_d[i] = lc_first[ioctl_pkg::ASSIGN_ROW[i]];
         end else if (src_q[i][ioctl_pkg::ROWF_LSB +: 2] < 2'h3) begin
            lines_d[i] = lc_first[src_q[i][ioctl_pkg::ROWF_LSB +: 2]];
         end else begin
            lines_d[i] = 1'b0;
         end
      end
   end

   // registered control bus; lines 6-11 double as clock enables
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         lines_q <= 12'h000;
      end else begin
         lines_q <= lines_d;
      end
   end

   // fan-out lines from their pin, or from a control line
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         fanout_q <= 4'h0;
      end else begin
         for (int g = 0; g < ioctl_pkg::NGLOB; g++) begin
            if (glob_q[ioctl_pkg::GINT_LSB + g]) begin
               fanout_q[g] <= lines_q[ioctl_pkg::GLOB_LINE[g]];
            end else begin
               fanout_q[g] <= ded_s[g];
            end
         end
      end
   end
   assign fanout_line = fanout_q;

   // io cells: six on row ends, two on the column end
   generate
      for (genvar c = 0; c < ioctl_pkg::NCELL; c++) begin : g_cell
         logic [17:0] row_sub;
         logic [15:0] col_sub;
         if (c < ioctl_pkg::COL_FIRST) begin : g_row
            assign row_sub = row_chan[c*ioctl_pkg::ROW_PER +: ioctl_pkg::ROW_PER];
            assign col_sub = 16'h0000;
         end else begin : g_col
            assign row_sub = 18'h00000;
            for (genvar k = 0; k < ioctl_pkg::COL_PER; k++) begin : g_k
               assign col_sub[k] = col_chan[((c - ioctl_pkg::COL_FIRST)
                  * ioctl_pkg::COL_STEP + k) % ioctl_pkg::COL_CH];
            end
         end
         ioctl_cell #(.COL_END(c >= ioctl_pkg::COL_FIRST)) u_cell (
            .ref_clk(ref_clk),
            .rstn(rstn),
            .chip_rst(chip_rst),
            .pins_off(pins_off),
            .cfg(cell_cfg_q[c]),
            .lines(lines_q),
            .dclk(dclk_s),
            .lc_ce(lc_ce[c]),
            .lc_oe(lc_oe[c]),
            .pad_in(pad_s[c]),
            .row_sub(row_sub),
            .col_sub(col_sub),
            .cell_q(cell_val[c]),
            .pad_oe_q(pad_oe[c])
         );
      end
   endgenerate
   assign pad_out = cell_val;

   // input cells place their value on two distinct channels; row-end cells only for lanes 0-8, otherwise on none
   always_comb begin
      int lane;
      int base;
      lane = 0;
      base = 0;
      row_drv_d = '0;
      col_drv_d = '0;
      for (int c = 0; c < ioctl_pkg::NCELL; c++) begin
         lane = int'(cell_cfg_q[c][ioctl_pkg::LANE_LSB +: 4]);
         if (cell_cfg_q[c][ioctl_pkg::DIR_BIT]) begin
            base = 0;
         end else if (c < ioctl_pkg::COL_FIRST) begin
            if (lane < ioctl_pkg::ROW_PER / 2) begin
               base = c * ioctl_pkg::ROW_PER + lane;
               row_drv_d[base] = cell_val[c];
               row_drv_d[base + ioctl_pkg::ROW_PER / 2] = cell_val[c];
            end
         end else begin
            base = ((c - ioctl_pkg::COL_FIRST) * ioctl_pkg::COL_STEP + (lane % 8))
               % ioctl_pkg::COL_CH;
            col_drv_d[base] = cell_val[c];
            col_drv_d[(base + ioctl_pkg::COL_STEP) % ioctl_pkg::COL_CH] = cell_val[c];
         end
      end
   end

   // registered channel drive
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         row_drive <= '0;
         col_drive <= '0;
      end else begin
         row_drive <= row_drv_d;
         col_drive <= col_drv_d;
      end
   end

   // checks
   property p_chip_rst;
      @(posedge ref_clk) disable iff (!rstn) chip_rst |=> (cell_val == 8'h00);
   endproperty
   a_chip_rst: assert property (p_chip_rst) else $error("cell not reset");

   property p_rst_pin;
      @(posedge ref_clk) disable iff (!rstn) (!chip_rstn_pin) [*3] |=> (cell_val == 8'h00);
   endproperty
   a_rst_pin: assert property (p_rst_pin) else $error("low reset pin ignored");

   property p_oe_off;
      @(posedge ref_clk) disable iff (!rstn)
         (glob_q[4] && !chip_oe_pin) [*3] |=> (pad_oe == 8'h00);
   endproperty
   a_oe_off: assert property (p_oe_off) else $error("pin driven while disabled");

   property p_line_src;
      @(posedge ref_clk) disable iff (!rstn)
         (src_q[0][2:0] == 3'h0) |=> (lines_q[0] == $past(ded_view[0]));
   endproperty
   a_line_src: assert property (p_line_src) else $error("line 0 source wrong");

   property p_glob;
      @(posedge ref_clk) disable iff (!rstn)
         glob_q[0] ##1 glob_q[0] |=> (fanout_q[0] == $past(lines_d[6], 2));
   endproperty
   a_glob: assert property (p_glob) else $error("fan-out 0 not from line");

   property p_disc;
      @(posedge ref_clk) disable iff (!rstn)
         (glob_q[0] && src_q[8][2:0] == 3'h0) |=> (lines_q[8] == 1'b0);
   endproperty
   a_disc: assert property (p_disc) else $error("disconnected pin still feeds");

   property p_row_in;
      @(posedge ref_clk) disable iff (!rstn)
         (!cell_cfg_q[0][0] && cell_cfg_q[0][24:21] == 4'h0)
         |=> (row_drive[0] == $past(cell_val[0]) && row_drive[9] == $past(cell_val[0]));
   endproperty
   a_row_in: assert property (p_row_in) else $error("row drive wrong");

   property p_clr;
      @(posedge ref_clk) disable iff (!rstn)
         (cell_cfg_q[0][4:3] == 2'h1 && lines_q[8]) |=> (cell_val[0] == 1'b0);
   endproperty
   a_clr: assert property (p_clr) else $error("clear did not act");

   c_rst: cover property (@(posedge ref_clk) disable iff (!rstn) $rose(chip_rst));
   c_glob: cover property (@(posedge ref_clk) disable iff (!rstn) glob_q[0] && fanout_q[0]);
   c_oe: cover property (@(posedge ref_clk) disable iff (!rstn) pad_oe != 8'h00);
   c_cap: cover property (@(posedge ref_clk) disable iff (!rstn) $rose(cell_val[0]));
endmodule

// *** testbench/ioctl_board.sv ***
`timescale 1ns/1ps
// board around the device pins: pad levels and dedicated pin drive
module ioctl_board (
   // pin side of the device
   input wire logic [7:0] pad_out,
   input wire logic [7:0] pad_oe,
   output logic [7:0] pad_in,
   output logic [5:0] ded_pin,
   // levels the board would put on the pins
   input wire logic [7:0] drv,
   input wire logic [5:0] ded_val,
   input wire logic [5:0] tie_low
);
   // a driven pad shows the device value, an undriven one the board level
   assign pad_in = (pad_oe & pad_out) | (~pad_oe & drv);
   // a pin whose fan-out line is fed from inside is grounded, never left open
   assign ded_pin = ded_val & ~tie_low;
endmodule

// *** testbench/test_io_cell_control_routing.sv ***
`timescale 1ns/1ps
module test_io_cell_control_routing;
   // clock, reset and register port
   logic ref_clk = 1'b0;
   logic rstn = 1'b0;
   logic [5:0] reg_addr = 6'h00;
   logic [31:0] reg_wdata = 32'h0000_0000;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic [31:0] reg_rdata;
   // device pins and the board behind them
   logic [5:0] ded_pin;
   logic [5:0] ded_val = 6'h00;
   logic [5:0] tie_low = 6'h00;
   logic [1:0] dclk_pin = 2'h0;
   logic chip_rstn_pin = 1'b1;
   logic chip_oe_pin = 1'b1;
   logic [7:0] pad_in;
   logic [7:0] drv = 8'h00;
   logic [7:0] pad_out;
   logic [7:0] pad_oe;
   // logic array side
   logic [2:0] lc_first = 3'h0;
   logic [7:0] lc_ce = 8'h00;
   logic [7:0] lc_oe = 8'h00;
   logic [143:0] row_chan = '0;
   logic [23:0] col_chan = '0;
   logic [143:0] row_drive;
   logic [23:0] col_drive;
   logic [3:0] fanout_line;
   // bench state
   int n_errors = 0;
   int check_count = 0;
   int cycles = 0;
   logic [31:0] seed = 32'ha724df50;
   logic [31:0] d;
   logic [2:0] src [6];

   // clock at 100 ns period
   initial begin
      forever #50 ref_clk = ~ref_clk;
   end

   ioctl_top i_dut (.ref_clk(ref_clk), .rstn(rstn), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .ded_pin(ded_pin), .dclk_pin(dclk_pin), .chip_rstn_pin(chip_rstn_pin),
      .chip_oe_pin(chip_oe_pin), .pad_in(pad_in), .pad_out(pad_out), .pad_oe(pad_oe),
      .lc_first(lc_first), .lc_ce(lc_ce), .lc_oe(lc_oe), .row_chan(row_chan),
      .col_chan(col_chan), .row_drive(row_drive), .col_drive(col_drive),
      .fanout_line(fanout_line));

   ioctl_board i_board (.pad_out(pad_out), .pad_oe(pad_oe), .pad_in(pad_in),
      .ded_pin(ded_pin), .drv(drv), .ded_val(ded_val), .tie_low(tie_low));

   // xorshift step for repeatable random values
   function automatic logic [31:0] xs(input logic [31:0] s);
      logic [31:0] x;
      x = s ^ (s << 13);
      x = x ^ (x >> 17);
      xs = x ^ (x << 5);
   endfunction

   // expected control lines from the chosen sources; lines 6-11 keep pin 0
   function automatic logic [11:0] exp_lines(input logic [2:0] s [6],
                                             input logic [5:0] dp, input logic [2:0] lc);
      exp_lines[11:6] = {6{dp[0]}};
      for (int i = 0; i < 6; i++) begin
         if (s[i] < 3'h6) begin
            exp_lines[i] = dp[s[i]];
         end else if (s[i] == 3'h6) begin
            exp_lines[i] = lc[ioctl_pkg::ASSIGN_ROW[i]];
         end else begin
            // column route from the row in the row field, row 3 gives zero
            exp_lines[i] = (i % 4 < 3) ? lc[i % 4] : 1'b0;
         end
      end
   endfunction

   // compare and count
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         n_errors++;
         $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   // counts, verdict and end of run
   task automatic print_verdict();
      $display("checks %0d errors %0d", check_count, n_errors);
      if (n_errors == 0 && check_count > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask

   // one-cycle register write
   task automatic wr(input logic [5:0] a, input logic [31:0] v);
      @(posedge ref_clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= v;
      @(posedge ref_clk);
      reg_wr <= 1'b0;
   endtask

   // one-cycle register read, data taken in the following cycle
   task automatic rd(input logic [5:0] a, output logic [31:0] v);
      @(posedge ref_clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge ref_clk);
      reg_rd <= 1'b0;
      #1;
      v = reg_rdata;
   endtask

   // let pin synchronisers and registered paths land
   task automatic settle();
      repeat (8) @(posedge ref_clk);
      #1;
   endtask

   // rising then falling edge on a dedicated clock pin
   task automatic pulse(input int k);
      @(posedge ref_clk);
      dclk_pin[k] <= 1'b1;
      repeat (4) @(posedge ref_clk);
      dclk_pin[k] <= 1'b0;
      settle();
   endtask

   // hang guard
   always @(posedge ref_clk) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         n_errors++;
         print_verdict();
      end
   end

   // main sequence
   initial begin
      repeat (2) @(posedge ref_clk);
      rstn <= 1'b1;
      // reset values, unmapped index
      rd(ioctl_pkg::ADDR_CELL0, d);
      check(d, ioctl_pkg::CELL_RST);
      rd(ioctl_pkg::ADDR_GLOB, d);
      check(d, ioctl_pkg::GLOB_RST);
      wr(6'h1F, 32'hFFFF_FFFF);
      rd(6'h1F, d);
      check(d, 32'h0000_0000);
      // random sources for the six output enable lines
      for (int n = 0; n < 4; n++) begin
         for (int i = 0; i < 6; i++) begin
            seed = xs(seed);
            src[i] = 3'(seed % 8);
            if (n == 3 && i > 2) begin
               src[i] = 3'h7;
            end
            wr(6'(i), {26'h0, 2'(i % 4), 1'b0, src[i]});
         end
         seed = xs(seed);
         ded_val <= seed[5:0];
         lc_first <= seed[8:6];
         settle();
         rd(ioctl_pkg::ADDR_STAT, d);
         check(d[19:8], exp_lines(src, seed[5:0], seed[8:6]));
         check(d[23:20], seed[3:0]);
      end
      ded_val <= 6'h00;
      // input capture on dedicated clock 0, always enabled
      wr(ioctl_pkg::ADDR_CELL0, 32'h0000_00E6);
      drv <= 8'h01;
      pulse(0);
      check(pad_out[0], 1'b1);
      check(row_drive[17:0], 18'h00201);
      // clock enable from the logic cell
      wr(ioctl_pkg::ADDR_CELL0, 32'h0000_00C6);
      drv <= 8'h00;
      pulse(0);
      check(pad_out[0], 1'b1);
      lc_ce <= 8'h01;
      pulse(0);
      check(pad_out[0], 1'b0);
      // clear from line 8, fed by pin 0
      wr(ioctl_pkg::ADDR_CELL0, 32'h0000_00EE);
      drv <= 8'h01;
      pulse(0);
      check(pad_out[0], 1'b1);
      ded_val <= 6'h01;
      settle();
      check(pad_out[0], 1'b0);
      ded_val <= 6'h00;
      // output cell 1 from row channel 18+5, enable on
      wr(6'h11, 32'h0000_59E5);
      row_chan[23] <= 1'b1;
      pulse(1);
      check({pad_oe[1], pad_out[1]}, 2'h3);
      check(pad_in[1], 1'b1);
      // chip output enable option floats the pins
      wr(ioctl_pkg::ADDR_GLOB, 32'h0000_0010);
      settle();
      check(pad_oe[1], 1'b1);
      chip_oe_pin <= 1'b0;
      settle();
      check(pad_oe, 8'h00);
      chip_oe_pin <= 1'b1;
      wr(ioctl_pkg::ADDR_GLOB, 32'h0000_0000);
      // chip reset overrides a clock edge
      chip_rstn_pin <= 1'b0;
      pulse(1);
      check(pad_out, 8'h00);
      rd(ioctl_pkg::ADDR_STAT, d);
      check(d[24], 1'b1);
      chip_rstn_pin <= 1'b1;
      settle();
      pulse(1);
      check(pad_out[1], 1'b1);
      // output enable of cell 1 from its logic cell
      wr(6'h11, 32'h0000_58E5);
      settle();
      check(pad_oe[1], 1'b0);
      lc_oe <= 8'h02;
      settle();
      check(pad_oe[1], 1'b1);
      // cell 2 clocked by line 11 from pin 2, cleared by line 10 from pin 3
      wr(6'h0B, 32'h0000_0002);
      wr(6'h0A, 32'h0000_0003);
      wr(6'h12, 32'h0000_00F2);
      drv <= 8'h04;
      ded_val <= 6'h04;
      settle();
      check(pad_out[2], 1'b1);
      ded_val <= 6'h0C;
      settle();
      check(pad_out[2], 1'b0);
      // fan-out 0 from line 6, its pin cut off
      wr(6'h06, 32'h0000_0001);
      wr(ioctl_pkg::ADDR_GLOB, 32'h0000_0001);
      ded_val <= 6'h01;
      settle();
      check(fanout_line[0], 1'b0);
      ded_val <= 6'h02;
      tie_low <= 6'h01;
      settle();
      check(fanout_line, 4'h3);
      // column input cell 6 on lane 1, output cell 7 on select 3
      wr(6'h16, 32'h0020_00E6);
      drv <= 8'h40;
      pulse(0);
      check(col_drive, 24'h000202);
      wr(6'h17, 32'h0006_09E5);
      col_chan[11] <= 1'b1;
      pulse(1);
      check(pad_out[7], 1'b1);
      print_verdict();
   end
endmodule
